// File: rtl/sesl_consts.svh
`ifndef SESL_CONSTS_SVH
`define SESL_CONSTS_SVH

// event and enable bit positions
`define SESL_BIT_OPC 0
`define SESL_BIT_QYE 2
`define SESL_BIT_DDE 3
`define SESL_BIT_EXE 4
`define SESL_BIT_CME 5
`define SESL_BIT_URQ 6
`define SESL_BIT_PON 7
`define SESL_EVT_BITS 8
// implemented enable bits: B1 and B8..B15 stay zero
`define SESL_ESE_MASK 16'h00FD
`define SESL_ESE_RESET 16'h0000
`define SESL_ESR_RESET 16'h0000
// status byte positions
`define SESL_STB_ESB 5
`define SESL_STB_RQS 6
`define SESL_SRE_MASK 8'hBF
`define SESL_SRE_RESET 8'h00
`define SESL_STB_RESET 8'h00
// answers
`define SESL_ASCII_ONE 16'h0031
`define SESL_TST_PASS 16'h0000
`define SESL_TST_FAIL 16'h0001
// setup store
`define SESL_SLOTS 4
`define SESL_SLOT_LIMIT 16'h0004
// program memory walked by the self test
`define SESL_ROM_LAST 8'hFF
`define SESL_ROM_SUM 16'h0000
// identity words, values are arbitrary
`define SESL_ID_MAKER 16'h0A5A
`define SESL_ID_MODEL 16'h0B01
`define SESL_ID_SERIAL 16'h0C02
`define SESL_ID_FWREV 16'h0D03
`define SESL_ID_LAST 2'h3
`define SESL_OPT_CODE 16'h0000

`endif

// File: rtl/sesl_pkg.sv
package sesl_pkg;

  typedef enum logic [4:0] {
    SESL_CMD_CLS = 5'h00,
    SESL_CMD_ESE = 5'h01,
    SESL_CMD_ESE_Q = 5'h02,
    SESL_CMD_ESR_Q = 5'h03,
    SESL_CMD_IDN_Q = 5'h04,
    SESL_CMD_OPC = 5'h05,
    SESL_CMD_OPC_Q = 5'h06,
    SESL_CMD_OPT_Q = 5'h07,
    SESL_CMD_RCL = 5'h08,
    SESL_CMD_RST = 5'h09,
    SESL_CMD_SAV = 5'h0A,
    SESL_CMD_SRE = 5'h0B,
    SESL_CMD_SRE_Q = 5'h0C,
    SESL_CMD_STB_Q = 5'h0D,
    SESL_CMD_TRG = 5'h0E,
    SESL_CMD_TST_Q = 5'h0F,
    SESL_CMD_WAI = 5'h10
  } sesl_cmd_t;

  typedef enum logic [1:0] {
    SESL_ST_IDLE = 2'b00,
    SESL_ST_WAIT = 2'b01,
    SESL_ST_IDN = 2'b11,
    SESL_ST_TST = 2'b10
  } sesl_state_t;

endpackage

// File: rtl/sesl_evt_bit.sv
`timescale 1ns/1ps
// one sticky event bit; a set in the clearing cycle survives
module sesl_evt_bit (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic q_o
);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_o <= 1'b0;
    end else if (set_i) begin
      q_o <= 1'b1;
    end else if (clr_i) begin
      q_o <= 1'b0;
    end
  end

endmodule // sesl_evt_bit

// File: rtl/sesl_top.sv
`timescale 1ns/1ps
`include "sesl_consts.svh"

// Summary of operation
// [R1] clear-status zeroes event register, signals outer registers and error queue clear
// [R2] clear-status returns both operation-complete trackers to idle
// [R3] enable command loads the mask from the host's numeric value
// [R4] mask bits: B0 OPC, B2 QYE, B3 DDE, B4 EXE, B5 CME, B6 URQ, B7 PON
// [R5] value 0 clears the mask, 255 sets every implemented bit
// [R6] enable mask is zero after power-up
// [R7] an enabled event sets the summary bit; masked events leave it alone
// [R8] command error sets B5, empty output queue read sets B2
// [R9] bits B8 to B15 read zero and never reach the summary
// [R10] event status query returns the register and then clears it
// [R11] operation-complete command sets B0 once nothing is pending
// [R12] operation-complete query queues ASCII 1 once nothing is pending
// [R13] service request enable loads its register; its query returns it
// [R14] status byte query returns the status byte with the summary bit
// [R15] wait command holds later commands until nothing is pending
// [R16] self-test sums program memory and returns pass or fail
// [R17] trigger command emits a bus trigger pulse
// [R18] save stores setup in a numbered slot; recall restores it
// [R19] identification query returns maker, model, serial and revision
// [R20] event register clears at power-up; B0 sets only via operation complete
// [R21] enable query returns the current mask value
module sesl_top
  import sesl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_valid_i,
  input sesl_cmd_t cmd_code_i,
  input wire logic [15:0] cmd_arg_i,
  output logic cmd_ready_o,
  input wire logic evt_qye_i,
  input wire logic evt_dde_i,
  input wire logic evt_exe_i,
  input wire logic evt_cme_i,
  input wire logic evt_urq_i,
  input wire logic evt_pon_i,
  input wire logic no_op_pend_i,
  input wire logic [7:0] stb_sum_i,
  input wire logic [15:0] setup_i,
  output logic [15:0] setup_o,
  output logic setup_load_o,
  input wire logic [15:0] rom_data_i,
  output logic [7:0] rom_addr_o,
  output logic resp_valid_o,
  output logic [15:0] resp_data_o,
  output logic resp_last_o,
  output logic clr_status_o,
  output logic trg_o,
  output logic dev_rst_o,
  output logic [15:0] ese_o,
  output logic [15:0] esr_o,
  output logic [7:0] stb_o,
  output logic srq_o
);

  sesl_state_t st_q;
  logic take;
  logic is_cls, is_ese, is_esr, is_opc, is_opcq, is_rst, is_sav, is_rcl;
  logic is_sre, is_trg, is_wai, is_idn, is_tst, bad_cmd, bad_slot;
  logic esr_clr, tracker_clr, opc_act_q, oq_act_q, opc_done, oq_fire;
  logic [`SESL_EVT_BITS-1:0] set_v;
  logic [`SESL_EVT_BITS-1:0] esr_bits;
  logic [15:0] ese_q;
  logic [7:0] sre_q;
  logic [7:0] stb_q;
  logic [7:0] stb_low;
  logic rqs, esb;
  logic [15:0] sum_q;
  logic [1:0] idn_idx_q;
  logic [15:0] slot_q [`SESL_SLOTS];
  logic [15:0] setup_q;
  logic setup_load_q, clr_status_q, trg_q, dev_rst_q;
  logic resp_v_d, resp_last_d, cmd_resp;
  logic [15:0] resp_data_d;
  logic resp_v_q, resp_last_q;
  logic [15:0] resp_data_q;
  logic [15:0] sum_next;

  // commands are only taken while idle; this is also what stalls the parser
  assign cmd_ready_o = (st_q == SESL_ST_IDLE);
  assign take = cmd_valid_i && cmd_ready_o;

  always_comb begin
    is_cls = 1'b0;
    is_ese = 1'b0;
    is_esr = 1'b0;
    is_opc = 1'b0;
    is_opcq = 1'b0;
    is_rst = 1'b0;
    is_sav = 1'b0;
    is_rcl = 1'b0;
    is_sre = 1'b0;
    is_trg = 1'b0;
    is_wai = 1'b0;
    is_idn = 1'b0;
    is_tst = 1'b0;
    bad_cmd = 1'b0;
    if (take) begin
      case (cmd_code_i)
        SESL_CMD_CLS: is_cls = 1'b1;
        SESL_CMD_ESE: is_ese = 1'b1;
        SESL_CMD_ESR_Q: is_esr = 1'b1;
        SESL_CMD_OPC: is_opc = 1'b1;
        SESL_CMD_OPC_Q: is_opcq = 1'b1;
        SESL_CMD_RST: is_rst = 1'b1;
        SESL_CMD_SAV: is_sav = 1'b1;
        SESL_CMD_RCL: is_rcl = 1'b1;
        SESL_CMD_SRE: is_sre = 1'b1;
        SESL_CMD_TRG: is_trg = 1'b1;
        SESL_CMD_WAI: is_wai = 1'b1;
        SESL_CMD_IDN_Q: is_idn = 1'b1;
        SESL_CMD_TST_Q: is_tst = 1'b1;
        SESL_CMD_ESE_Q, SESL_CMD_SRE_Q, SESL_CMD_STB_Q, SESL_CMD_OPT_Q: ;
        // an unknown code from the parser is reported as a command error
        default: bad_cmd = 1'b1;
      endcase
    end
  end

  // out-of-range slot numbers are refused as execution errors
  assign bad_slot = (is_sav || is_rcl) && (cmd_arg_i >= `SESL_SLOT_LIMIT); // R18

  // standard event register
  assign esr_clr = is_cls || is_esr; // R1 R10
  always_comb begin
    set_v = '0;
    set_v[`SESL_BIT_OPC] = opc_done; // R20
    set_v[`SESL_BIT_QYE] = evt_qye_i; // R8
    set_v[`SESL_BIT_DDE] = evt_dde_i;
    set_v[`SESL_BIT_EXE] = evt_exe_i || bad_slot;
    set_v[`SESL_BIT_CME] = evt_cme_i || bad_cmd; // R8
    set_v[`SESL_BIT_URQ] = evt_urq_i;
    set_v[`SESL_BIT_PON] = evt_pon_i;
  end

  for (genvar i = 0; i < `SESL_EVT_BITS; i++) begin : g_evt
    sesl_evt_bit u_bit (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .set_i(set_v[i]),
      .clr_i(esr_clr),
      .q_o(esr_bits[i])
    );
  end

  assign esr_o = {8'h00, esr_bits}; // R9

  // enable mask, cleared at power-up
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ese_q <= `SESL_ESE_RESET; // R6
    end else if (is_ese) begin
      ese_q <= cmd_arg_i & `SESL_ESE_MASK; // R3 R4 R5 R9
    end
  end
  assign ese_o = ese_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sre_q <= `SESL_SRE_RESET;
    end else if (is_sre) begin
      sre_q <= cmd_arg_i[7:0] & `SESL_SRE_MASK; // R13
    end
  end

  // status byte; summary is a level that follows register and mask
  assign esb = |(esr_bits & ese_q[7:0]); // R7
  always_comb begin
    stb_low = stb_sum_i;
    stb_low[`SESL_STB_ESB] = esb;
    stb_low[`SESL_STB_RQS] = 1'b0;
  end
  assign rqs = |(stb_low & sre_q);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stb_q <= `SESL_STB_RESET;
    end else begin
      stb_q <= stb_low | ({7'h00, rqs} << `SESL_STB_RQS); // R7
    end
  end
  assign stb_o = stb_q;
  assign srq_o = stb_q[`SESL_STB_RQS];

  // operation-complete trackers
  assign tracker_clr = is_cls || is_rst; // R2
  assign opc_done = opc_act_q && no_op_pend_i && !tracker_clr; // R11
  // the queued '1' yields to any other answer in the same cycle
  assign oq_fire = oq_act_q && no_op_pend_i && !tracker_clr && !cmd_resp; // R12
  // kept apart from the answer mux so the queued '1' does not loop through it
  assign cmd_resp = (st_q == SESL_ST_IDN) || is_esr
    || (st_q == SESL_ST_TST && rom_addr_o == `SESL_ROM_LAST)
    || (take && (cmd_code_i inside {SESL_CMD_ESE_Q, SESL_CMD_SRE_Q,
                                    SESL_CMD_STB_Q, SESL_CMD_OPT_Q}));

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opc_act_q <= 1'b0;
    end else if (tracker_clr) begin
      opc_act_q <= 1'b0; // R2
    end else if (is_opc) begin
      opc_act_q <= 1'b1; // R11
    end else if (opc_done) begin
      opc_act_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oq_act_q <= 1'b0;
    end else if (tracker_clr) begin
      oq_act_q <= 1'b0; // R2
    end else if (is_opcq) begin
      oq_act_q <= 1'b1; // R12
    end else if (oq_fire) begin
      oq_act_q <= 1'b0;
    end
  end

  // sequencer for wait, identification and self test
  assign sum_next = sum_q + rom_data_i;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= SESL_ST_IDLE;
    end else begin
      unique case (st_q)
        SESL_ST_IDLE: begin
          if (is_wai) begin
            st_q <= SESL_ST_WAIT; // R15
          end else if (is_idn) begin
            st_q <= SESL_ST_IDN;
          end else if (is_tst) begin
            st_q <= SESL_ST_TST;
          end
        end
        SESL_ST_WAIT: if (no_op_pend_i) st_q <= SESL_ST_IDLE; // R15
        SESL_ST_IDN: if (idn_idx_q == `SESL_ID_LAST) st_q <= SESL_ST_IDLE;
        SESL_ST_TST: if (rom_addr_o == `SESL_ROM_LAST) st_q <= SESL_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rom_addr_o <= 8'h00;
      sum_q <= 16'h0000;
    end else if (st_q == SESL_ST_TST) begin
      rom_addr_o <= rom_addr_o + 8'h01; // R16
      sum_q <= sum_next;
    end else begin
      rom_addr_o <= 8'h00;
      sum_q <= 16'h0000;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idn_idx_q <= 2'h0;
    end else if (st_q == SESL_ST_IDN) begin
      idn_idx_q <= idn_idx_q + 2'h1;
    end else begin
      idn_idx_q <= 2'h0;
    end
  end

  // answers toward the output queue
  always_comb begin
    resp_v_d = 1'b1;
    resp_last_d = 1'b1;
    resp_data_d = 16'h0000;
    if (st_q == SESL_ST_IDN) begin
      resp_last_d = (idn_idx_q == `SESL_ID_LAST);
      unique case (idn_idx_q)
        2'h0: resp_data_d = `SESL_ID_MAKER; // R19
        2'h1: resp_data_d = `SESL_ID_MODEL;
        2'h2: resp_data_d = `SESL_ID_SERIAL;
        2'h3: resp_data_d = `SESL_ID_FWREV;
      endcase
    end else if (st_q == SESL_ST_TST && rom_addr_o == `SESL_ROM_LAST) begin
      resp_data_d = (sum_next == `SESL_ROM_SUM) ? `SESL_TST_PASS : `SESL_TST_FAIL; // R16
    end else if (take && cmd_code_i == SESL_CMD_ESE_Q) begin
      resp_data_d = ese_q; // R21
    end else if (is_esr) begin
      resp_data_d = esr_o; // R10
    end else if (take && cmd_code_i == SESL_CMD_SRE_Q) begin
      resp_data_d = {8'h00, sre_q}; // R13
    end else if (take && cmd_code_i == SESL_CMD_STB_Q) begin
      resp_data_d = {8'h00, stb_q}; // R14
    end else if (take && cmd_code_i == SESL_CMD_OPT_Q) begin
      resp_data_d = `SESL_OPT_CODE;
    end else begin
      resp_v_d = oq_fire;
      resp_data_d = oq_fire ? `SESL_ASCII_ONE : 16'h0000; // R12
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resp_v_q <= 1'b0;
      resp_last_q <= 1'b0;
      resp_data_q <= 16'h0000;
    end else begin
      resp_v_q <= resp_v_d;
      resp_last_q <= resp_v_d && resp_last_d;
      if (resp_v_d) resp_data_q <= resp_data_d;
    end
  end
  assign resp_valid_o = resp_v_q;
  assign resp_last_o = resp_last_q;
  assign resp_data_o = resp_data_q;

  // setup store
  always_ff @(posedge sys_clk_i) begin
    if (is_sav && !bad_slot) slot_q[cmd_arg_i[1:0]] <= setup_i; // R18
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      setup_q <= 16'h0000;
      setup_load_q <= 1'b0;
    end else begin
      setup_load_q <= is_rcl && !bad_slot;
      if (is_rcl && !bad_slot) setup_q <= slot_q[cmd_arg_i[1:0]]; // R18
    end
  end
  assign setup_o = setup_q;
  assign setup_load_o = setup_load_q;

  // strobes to the rest of the instrument
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clr_status_q <= 1'b0;
      trg_q <= 1'b0;
      dev_rst_q <= 1'b0;
    end else begin
      clr_status_q <= is_cls; // R1
      trg_q <= is_trg; // R17
      dev_rst_q <= is_rst;
    end
  end
  assign clr_status_o = clr_status_q;
  assign trg_o = trg_q;
  assign dev_rst_o = dev_rst_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_CLS_ZERO: assert property (is_cls && set_v == '0 |=> esr_o == 16'h0000 && clr_status_o) // R1
    else $error("clear status left events set");
  AST_CLS_IDLE: assert property (is_cls |=> !opc_act_q && !oq_act_q) // R2
    else $error("clear status left a tracker active");
  AST_ESE_LOAD: assert property (is_ese |=> ese_o == ($past(cmd_arg_i) & `SESL_ESE_MASK)) // R3
    else $error("enable mask not loaded");
  AST_UNUSED_ZERO: assert property (ese_o[15:8] == 8'h00 && ese_o[1] == 1'b0 && esr_o[15:8] == 8'h00) // R9
    else $error("unused bit set");
  AST_ESB_FOLLOW: assert property (|(esr_o[7:0] & ese_o[7:0]) |=> stb_o[`SESL_STB_ESB]) // R7
    else $error("enabled event missed summary");
  AST_ESB_MASKED: assert property (!(|(esr_o[7:0] & ese_o[7:0])) |=> !stb_o[`SESL_STB_ESB]) // R7
    else $error("masked event set summary");
  AST_CME_SET: assert property (evt_cme_i |=> esr_o[`SESL_BIT_CME]) // R8
    else $error("command error not recorded");
  AST_QYE_SET: assert property (evt_qye_i |=> esr_o[`SESL_BIT_QYE]) // R8
    else $error("query error not recorded");
  AST_ESR_READ: assert property (is_esr |=> resp_valid_o && resp_data_o == $past(esr_o)) // R10
    else $error("event status answer wrong");
  AST_OPC_CAUSE: assert property ($rose(esr_o[`SESL_BIT_OPC]) |-> $past(opc_act_q)) // R20
    else $error("complete bit set without tracker");
  AST_OPC_DONE: assert property (is_opc ##1 no_op_pend_i |=> esr_o[`SESL_BIT_OPC]) // R11
    else $error("complete bit not set");
  AST_OQ_ONE: assert property (oq_fire |=> resp_valid_o && resp_data_o == `SESL_ASCII_ONE) // R12
    else $error("ascii one not queued");
  AST_WAI_HOLD: assert property (st_q == SESL_ST_WAIT && !no_op_pend_i |=> !cmd_ready_o) // R15
    else $error("wait released early");
  AST_TST_DONE: assert property (is_tst |-> ##[1:300] resp_valid_o) // R16
    else $error("self test never answered");
  AST_TRG_PULSE: assert property (is_trg |=> trg_o ##1 !trg_o) // R17
    else $error("trigger pulse wrong");

  COV_ESR_READ: cover property (is_esr && esr_o != 16'h0000);
  COV_OPC_SET: cover property (opc_done);
  COV_IDN_LAST: cover property (resp_last_o && st_q == SESL_ST_IDLE);
  COV_WAI: cover property (st_q == SESL_ST_WAIT ##1 st_q == SESL_ST_IDLE);

endmodule // sesl_top

// File: tb/sesl_rom_model.sv
`timescale 1ns/1ps
// program memory whose words sum to zero; bad_i spoils word 0 so the self test must fail
module sesl_rom_model (
  input wire logic [7:0] addr_i,
  input wire logic bad_i,
  output logic [15:0] data_o
);
  logic [15:0] rest;
  always_comb begin
    rest = 16'h0000;
    for (int a = 1; a < 256; a++) begin
      rest = rest + (16'(a) ^ 16'h5A5A);
    end
    if (addr_i == 8'h00) begin
      data_o = 16'h0000 - rest + 16'(bad_i);
    end else begin
      data_o = {8'h00, addr_i} ^ 16'h5A5A;
    end
  end
endmodule // sesl_rom_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
`include "sesl_consts.svh"
module tb_top import sesl_pkg::*; ;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  sesl_cmd_t cmd_code_i = SESL_CMD_CLS;
  logic [15:0] cmd_arg_i = 16'h0000;
  logic [5:0] evt_v = 6'h00;
  logic no_op_pend_i = 1'b1;
  logic [7:0] stb_sum_i = 8'h00;
  logic [15:0] setup_i = 16'h0000;
  logic rom_bad = 1'b0;
  logic [15:0] rom_data_i, setup_o, resp_data_o, ese_o, esr_o, m, sv[4];
  logic [7:0] rom_addr_o, stb_o, s, st;
  logic [5:0] v;
  logic cmd_ready_o, setup_load_o, resp_valid_o, resp_last_o;
  logic clr_status_o, trg_o, dev_rst_o, srq_o;
  logic [15:0] rsp_q[$];
  logic [15:0] ese_tab[10] = '{16'h0000, 16'h0001, 16'h0004, 16'h0008, 16'h0010,
    16'h0020, 16'h0040, 16'h0080, 16'h00FF, 16'hFFFF};
  logic [15:0] id_tab[4] = '{`SESL_ID_MAKER, `SESL_ID_MODEL, `SESL_ID_SERIAL, `SESL_ID_FWREV};
  int err_count = 0;
  int checked = 0;
  int seed = 32'h8EEA796D;
  int n_last = 0, n_clr = 0, n_trg = 0, n_rst = 0, n_ld = 0, n0;

  sesl_top dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .cmd_arg_i(cmd_arg_i), .cmd_ready_o(cmd_ready_o),
    .evt_qye_i(evt_v[0]), .evt_dde_i(evt_v[1]), .evt_exe_i(evt_v[2]), .evt_cme_i(evt_v[3]),
    .evt_urq_i(evt_v[4]), .evt_pon_i(evt_v[5]), .no_op_pend_i(no_op_pend_i),
    .stb_sum_i(stb_sum_i), .setup_i(setup_i), .setup_o(setup_o), .setup_load_o(setup_load_o),
    .rom_data_i(rom_data_i), .rom_addr_o(rom_addr_o), .resp_valid_o(resp_valid_o),
    .resp_data_o(resp_data_o), .resp_last_o(resp_last_o), .clr_status_o(clr_status_o),
    .trg_o(trg_o), .dev_rst_o(dev_rst_o), .ese_o(ese_o), .esr_o(esr_o), .stb_o(stb_o),
    .srq_o(srq_o));
  sesl_rom_model rom (.addr_i(rom_addr_o), .bad_i(rom_bad), .data_o(rom_data_i));

  always #2.5 sys_clk_i = ~sys_clk_i;

  // answer words and strobes are one-cycle events, so they are tallied at every rising edge
  always @(posedge sys_clk_i) begin
    if (resp_valid_o === 1'b1) rsp_q.push_back(resp_data_o);
    if (resp_valid_o === 1'b1 && resp_last_o === 1'b1) n_last++;
    if (clr_status_o === 1'b1) n_clr++;
    if (trg_o === 1'b1) n_trg++;
    if (dev_rst_o === 1'b1) n_rst++;
    if (setup_load_o === 1'b1) n_ld++;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic fin(input string name);
    $display("test %s done, %0d mismatches so far", name, err_count);
  endtask
  task automatic send(input sesl_cmd_t c, input logic [15:0] a);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    while (cmd_ready_o !== 1'b1 && n < 400) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 400) err_count++;
    cmd_valid_i = 1'b1;
    cmd_code_i = c;
    cmd_arg_i = a;
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b0;
  endtask
  task automatic take(input logic [15:0] exp);
    int n;
    n = 0;
    while (rsp_q.size() == 0 && n < 400) begin
      tick(1);
      n++;
    end
    if (rsp_q.size() == 0) rsp_q.push_back(16'hXXXX);
    chk(rsp_q.pop_front(), exp);
  endtask
  task automatic query(input sesl_cmd_t c, input logic [15:0] a, input logic [15:0] exp);
    rsp_q.delete();
    send(c, a);
    take(exp);
  endtask
  task automatic pulse(input logic [5:0] e);
    @(negedge sys_clk_i);
    evt_v = e;
    @(negedge sys_clk_i);
    evt_v = 6'h00;
    tick(2);
  endtask
  function automatic logic [7:0] exp_stb(input logic [7:0] sum, esr, ese, sre);
    logic [7:0] b;
    b = {sum[7], 1'b0, |(esr & ese), sum[4:0]};
    b[6] = |(b & sre & `SESL_SRE_MASK);
    return b;
  endfunction

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #(30000 * 5);
    err_count++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    tick(1);
    chk(ese_o, `SESL_ESE_RESET);
    chk(esr_o, `SESL_ESR_RESET);
    chk(cmd_ready_o, 1'b1);
    fin("reset");
    foreach (ese_tab[i]) begin
      send(SESL_CMD_ESE, ese_tab[i]);
      query(SESL_CMD_ESE_Q, 16'h0000, ese_tab[i] & `SESL_ESE_MASK);
    end
    fin("mask table");
    stb_sum_i = 8'h9F;
    for (int i = 0; i < 16; i++) begin
      m = $random(seed);
      v = $random(seed);
      send(SESL_CMD_ESE, m);
      pulse(v);
      chk(ese_o, m & `SESL_ESE_MASK);
      chk(esr_o, {8'h00, v, 2'b00});
      chk(stb_o[5], |({v, 2'b00} & m[7:0] & 8'hFD));
      query(SESL_CMD_ESR_Q, 16'h0000, {8'h00, v, 2'b00});
      tick(2);
      chk(esr_o, 16'h0000);
      chk(stb_o[5], 1'b0);
    end
    fin("random events");
    s = $random(seed);
    rsp_q.delete();
    send(SESL_CMD_SRE, {8'h00, s});
    tick(2);
    chk(16'(rsp_q.size()), 16'h0000);
    query(SESL_CMD_SRE_Q, 16'h0000, {8'h00, s & `SESL_SRE_MASK});
    send(SESL_CMD_ESE, 16'h0024);
    pulse(6'h08);
    st = exp_stb(stb_sum_i, 8'h20, 8'h24, s);
    chk(stb_o, st);
    query(SESL_CMD_STB_Q, 16'h0000, {8'h00, st});
    chk(srq_o, st[6]);
    fin("status byte");
    n0 = n_clr;
    query(SESL_CMD_ESR_Q, 16'h0000, 16'h0020);
    send(sesl_cmd_t'(5'h1F), 16'h0000);
    tick(2);
    chk(esr_o[5], 1'b1);
    send(SESL_CMD_CLS, 16'h0000);
    tick(2);
    chk(esr_o, 16'h0000);
    chk(16'(n_clr - n0), 16'h0001);
    no_op_pend_i = 1'b0;
    send(SESL_CMD_OPC, 16'h0000);
    tick(5);
    chk(esr_o[0], 1'b0);
    no_op_pend_i = 1'b1;
    tick(3);
    chk(esr_o[0], 1'b1);
    send(SESL_CMD_CLS, 16'h0000);
    no_op_pend_i = 1'b0;
    rsp_q.delete();
    send(SESL_CMD_OPC, 16'h0000);
    send(SESL_CMD_OPC_Q, 16'h0000);
    tick(3);
    chk(16'(rsp_q.size()), 16'h0000);
    send(SESL_CMD_CLS, 16'h0000);
    tick(2);
    no_op_pend_i = 1'b1;
    tick(6);
    chk(esr_o[0], 1'b0);
    chk(16'(rsp_q.size()), 16'h0000);
    query(SESL_CMD_OPC_Q, 16'h0000, `SESL_ASCII_ONE);
    send(SESL_CMD_OPC, 16'h0000);
    tick(2);
    chk(esr_o[0], 1'b1);
    query(SESL_CMD_OPT_Q, 16'h0000, `SESL_OPT_CODE);
    fin("operation complete");
    no_op_pend_i = 1'b0;
    send(SESL_CMD_WAI, 16'h0000);
    tick(3);
    chk(cmd_ready_o, 1'b0);
    no_op_pend_i = 1'b1;
    tick(3);
    chk(cmd_ready_o, 1'b1);
    query(SESL_CMD_TST_Q, 16'h0000, `SESL_TST_PASS);
    rom_bad = 1'b1;
    query(SESL_CMD_TST_Q, 16'h0000, `SESL_TST_FAIL);
    rom_bad = 1'b0;
    n0 = n_trg;
    send(SESL_CMD_TRG, 16'h0000);
    tick(2);
    chk(16'(n_trg - n0), 16'h0001);
    n0 = n_rst;
    send(SESL_CMD_RST, 16'h0000);
    tick(2);
    chk(16'(n_rst - n0), 16'h0001);
    n0 = n_last;
    query(SESL_CMD_IDN_Q, 16'h0000, id_tab[0]);
    for (int i = 1; i < 4; i++) take(id_tab[i]);
    tick(2);
    chk(16'(n_last - n0), 16'h0001);
    fin("misc commands");
    for (int k = 0; k < 4; k++) begin
      sv[k] = $random(seed);
      setup_i = sv[k];
      send(SESL_CMD_SAV, 16'(k));
    end
    setup_i = 16'h0000;
    for (int k = 3; k >= 0; k--) begin
      n0 = n_ld;
      send(SESL_CMD_RCL, 16'(k));
      tick(2);
      chk(setup_o, sv[k]);
      chk(16'(n_ld - n0), 16'h0001);
    end
    n0 = n_ld;
    send(SESL_CMD_RCL, `SESL_SLOT_LIMIT);
    tick(2);
    chk(esr_o[4], 1'b1);
    chk(16'(n_ld - n0), 16'h0000);
    fin("setup store");
    send(SESL_CMD_ESE, 16'h00FF);
    pulse(6'h3F);
    @(negedge sys_clk_i);
    rst_b_i = 1'b0;
    tick(2);
    rst_b_i = 1'b1;
    tick(1);
    chk(ese_o, 16'h0000);
    chk(esr_o, 16'h0000);
    fin("second reset");
    test_done();
  end
endmodule // tb_top
